// ==== include/gdtg_regs.vh ====
/*
 * Constants of the grid deviation telegram generator: register offsets,
 * field positions, reset values, telegram lengths and timing counts.
 * Assumes a 200 MHz system clock and a 32-bit AHB-Lite register port.
 */
// Notes on behaviour
// R1: extended calendar telegram is 42 characters
// R2: extended telegram each second, ends CR LF
// R3: date field T:, yy:mm:dd:wd then hh:mm:ss
// R4: D: sign, zero digit, two digits, three decimals
// R5: F: measured frequency, two digits, three decimals
// R6: compact telegram 34 characters, T and F
// R7: T or ? requests compact telegram next second
// R8: request reply stamped next second, ms 000
// R9: F27 B3 PS correction, echo F27, apply
// R10: third format yday time, then sync character
// R11: third format T, F, SF fields follow
// R12: third format ends ST mains time, CR LF
// R13: eight error flags, X8/X7 analog overflows
// R14: X6 deviation overflow, X5 frequency limits
// R15: X4 no pulse, X3 mains absent, X2 string
// R16: X1 mains time not initialised
// R17: E on either port returns ERROR flags
// R18: fixed width zero padded numeric fields
`ifndef GDTG_REGS_VH
`define GDTG_REGS_VH

`define GDTG_OFS_CTRL        8'h00
`define GDTG_OFS_FLAGS       8'h04
`define GDTG_OFS_INT_STATUS  8'h08
`define GDTG_OFS_INT_MASK    8'h0C
`define GDTG_OFS_FD_MAX      8'h10
`define GDTG_OFS_FD_MIN      8'h14
`define GDTG_OFS_CORR        8'h18

`define GDTG_CTRL_MODE_LSB   0
`define GDTG_CTRL_MODE_MSB   1
`define GDTG_CTRL_EN_BIT     2
`define GDTG_CTRL_RESET      3'h4
`define GDTG_MODE_EXTENDED   2'h0
`define GDTG_MODE_REQUEST    2'h1
`define GDTG_MODE_THIRD      2'h2
`define GDTG_FD_MAX_RESET    16'h0500
`define GDTG_FD_MIN_RESET    16'h0500

`define GDTG_INT_SENT        0
`define GDTG_INT_REQUEST     1
`define GDTG_INT_CORR        2
`define GDTG_INT_FLAG        3

`define GDTG_LEN_EXTENDED    6'h2A
`define GDTG_LEN_COMPACT     6'h22
`define GDTG_LEN_THIRD       6'h35
`define GDTG_LEN_ERROR       6'h10
`define GDTG_LEN_ECHO        6'h05
`define GDTG_PREFIX          80'h46323720423320505320
`define GDTG_PREFIX_LEN      4'hA

`define GDTG_CLK_MHZ         200
`define GDTG_REF_TIMEOUT_MS  1100
`define GDTG_REF_TIMEOUT_CYC 28'hD1CEF00

`endif

// ==== core/gdtg_top.v ====
/*
 * Telegram generator and command responder of a mains deviation monitor.
 * Builds the extended, compact and third-format telegrams, keeps eight
 * error flags, answers E queries and takes time deviation corrections.
 * Assumes: measured values arrive as BCD from logic on sys_clk, the
 * reference seconds pulse is an asynchronous pin, and UARTs on sys_clk
 * hand bytes over by valid/ready.
 */
`timescale 1ns/1ps
`include "gdtg_regs.vh"

module gdtg_top #(
	parameter [27:0] REF_TIMEOUT_CYC = `GDTG_REF_TIMEOUT_CYC
) (
	// clock, reset, enable
	input  wire        sys_clk,
	input  wire        rst,
	input  wire        ce,
	// reference second pulse pin
	input  wire        ref_pulse,
	// reference date and time, bcd
	input  wire [7:0]  ref_year,
	input  wire [7:0]  ref_month,
	input  wire [7:0]  ref_day,
	input  wire [3:0]  ref_wday,
	input  wire [11:0] ref_yday,
	input  wire [7:0]  ref_hour,
	input  wire [7:0]  ref_min,
	input  wire [7:0]  ref_sec,
	input  wire        synced,
	// measured values, bcd
	input  wire        time_deviation_neg,
	input  wire [19:0] time_deviation,
	input  wire        time_deviation_over,
	input  wire        frequency_deviation_neg,
	input  wire [15:0] frequency_deviation,
	input  wire [19:0] measured_frequency,
	input  wire [23:0] mains_derived_time,
	input  wire [11:0] mains_derived_ms,
	// conditions for the error flags
	input  wire        analog2_overflow,
	input  wire        analog1_overflow,
	input  wire        mains_absent,
	input  wire        time_string_missing,
	input  wire        mains_time_uninit,
	// serial ports, receive side
	input  wire        rx0_valid,
	input  wire [7:0]  rx0_data,
	output wire        rx0_ready,
	input  wire        rx1_valid,
	input  wire [7:0]  rx1_data,
	output wire        rx1_ready,
	// serial transmit byte stream
	output wire        tx_valid,
	output wire [7:0]  tx_data,
	input  wire        tx_ready,
	// deviation correction to the monitor
	output reg         corr_load,
	output reg         corr_neg,
	output reg  [19:0] corr_value,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	// interrupt
	output wire        irq
);

	localparam [2:0] P_IDLE   = 3'h0;
	localparam [2:0] P_PREFIX = 3'h1;
	localparam [2:0] P_SIGN   = 3'h2;
	localparam [2:0] P_DIGITS = 3'h3;
	localparam [2:0] P_LF     = 3'h4;

	function [7:0] dg;
		input [3:0] d;
		dg = {4'h3, d};
	endfunction

	function [7:0] sg;
		input n;
		sg = n ? "-" : "+";
	endfunction

	// registers
	reg  [2:0]   ctrl_q;
	reg  [15:0]  fd_max_q;
	reg  [15:0]  fd_min_q;
	reg  [3:0]   int_status_q;
	reg  [3:0]   int_mask_q;
	reg  [7:0]   flags_q;
	reg          wr_pend_q;
	reg  [7:0]   wr_addr_q;
	// pulse synchroniser
	reg          sync1_q;
	reg          sync2_q;
	reg          sync3_q;
	reg          pulse_lvl_q;
	reg  [27:0]  ref_cnt_q;
	// transmitter
	reg  [423:0] msg_q;
	reg  [5:0]   left_q;
	reg          sec_pend_q;
	reg          req_pend_q;
	reg          err_pend_q;
	reg          echo_pend_q;
	// parser
	reg  [2:0]   pstate_q;
	reg  [3:0]   pidx_q;
	reg  [2:0]   ndig_q;
	reg          pneg_q;
	reg  [19:0]  pacc_q;

	wire         ahb_go   = hsel & htrans[1] & hready;
	wire [1:0]   mode     = ctrl_q[`GDTG_CTRL_MODE_MSB:`GDTG_CTRL_MODE_LSB];
	wire         enabled  = ctrl_q[`GDTG_CTRL_EN_BIT];
	wire         sec_edge = ce & (sync2_q == sync3_q) & sync3_q & ~pulse_lvl_q;
	wire         rx_valid = rx0_valid | rx1_valid;
	wire [7:0]   rx_byte  = rx0_valid ? rx0_data : rx1_data;
	wire         rx_take  = ce & rx_valid;
	wire         tx_busy  = (left_q != 6'h00);
	wire         tx_fire  = ce & tx_busy & tx_ready;
	wire         tx_last  = tx_fire & (left_q == 6'h01);
	wire         is_digit = (rx_byte >= "0") && (rx_byte <= "9");

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign rx0_ready = 1'b1;
	assign rx1_ready = ~rx0_valid;                                                 // R17
	assign tx_valid  = tx_busy;
	assign tx_data   = msg_q[423:416];
	assign irq       = |(int_status_q & int_mask_q);

	// telegram images, left aligned in the shift register
	wire [335:0] ext_w = {"T:", dg(ref_year[7:4]), dg(ref_year[3:0]), ":",        // R1 R3
		dg(ref_month[7:4]), dg(ref_month[3:0]), ":",
		dg(ref_day[7:4]), dg(ref_day[3:0]), ":", "0", dg(ref_wday), ":",
		dg(ref_hour[7:4]), dg(ref_hour[3:0]), ":",
		dg(ref_min[7:4]), dg(ref_min[3:0]), ":",
		dg(ref_sec[7:4]), dg(ref_sec[3:0]),
		"D:", sg(time_deviation_neg), "0",                                     // R4
		dg(time_deviation[19:16]), dg(time_deviation[15:12]), ".",
		dg(time_deviation[11:8]), dg(time_deviation[7:4]), dg(time_deviation[3:0]),
		"F:", dg(measured_frequency[19:16]), dg(measured_frequency[15:12]), ".", // R5
		dg(measured_frequency[11:8]), dg(measured_frequency[7:4]),
		dg(measured_frequency[3:0]), 16'h0D0A};                                // R2

	// the reply goes out at the new second, so its stamp is that second
	wire [271:0] cmp_w = {dg(ref_yday[11:8]), dg(ref_yday[7:4]), dg(ref_yday[3:0]),
		":", dg(ref_hour[7:4]), dg(ref_hour[3:0]), ":",
		dg(ref_min[7:4]), dg(ref_min[3:0]), ":",
		dg(ref_sec[7:4]), dg(ref_sec[3:0]), ".000",                            // R8
		" T", sg(time_deviation_neg),                                          // R6 R18
		dg(time_deviation[19:16]), dg(time_deviation[15:12]), ".",
		dg(time_deviation[11:8]), dg(time_deviation[7:4]), dg(time_deviation[3:0]),
		"F", sg(frequency_deviation_neg), dg(frequency_deviation[15:12]), ".",
		dg(frequency_deviation[11:8]), dg(frequency_deviation[7:4]),
		dg(frequency_deviation[3:0]), 16'h0D0A};

	wire [423:0] thd_w = {dg(ref_yday[11:8]), dg(ref_yday[7:4]), dg(ref_yday[3:0]),
		":", dg(ref_hour[7:4]), dg(ref_hour[3:0]), ":",                        // R10
		dg(ref_min[7:4]), dg(ref_min[3:0]), ":",
		dg(ref_sec[7:4]), dg(ref_sec[3:0]), synced ? " " : "?",
		"T", sg(time_deviation_neg),                                           // R11
		dg(time_deviation[19:16]), dg(time_deviation[15:12]), ".",
		dg(time_deviation[11:8]), dg(time_deviation[7:4]), dg(time_deviation[3:0]),
		"F", sg(frequency_deviation_neg), dg(frequency_deviation[15:12]), ".",
		dg(frequency_deviation[11:8]), dg(frequency_deviation[7:4]),
		dg(frequency_deviation[3:0]),
		"SF+", dg(measured_frequency[19:16]), dg(measured_frequency[15:12]), ".",
		dg(measured_frequency[11:8]), dg(measured_frequency[7:4]),
		dg(measured_frequency[3:0]),
		"ST", dg(mains_derived_time[23:20]), dg(mains_derived_time[19:16]), ":", // R12
		dg(mains_derived_time[15:12]), dg(mains_derived_time[11:8]), ":",
		dg(mains_derived_time[7:4]), dg(mains_derived_time[3:0]), ".",
		dg(mains_derived_ms[11:8]), dg(mains_derived_ms[7:4]),
		dg(mains_derived_ms[3:0]), 16'h0D0A};

	wire [127:0] err_w = {"ERROR:", dg({3'h0, flags_q[7]}), dg({3'h0, flags_q[6]}), // R17
		dg({3'h0, flags_q[5]}), dg({3'h0, flags_q[4]}), dg({3'h0, flags_q[3]}),
		dg({3'h0, flags_q[2]}), dg({3'h0, flags_q[1]}), dg({3'h0, flags_q[0]}),
		16'h0D0A};

	wire [39:0]  echo_w = {"F27", 16'h0D0A};                                      // R9

	// error flags follow the conditions every cycle
	wire fd_over = frequency_deviation_neg ? (frequency_deviation > fd_min_q)
		: (frequency_deviation > fd_max_q);
	wire ref_lost = (ref_cnt_q >= REF_TIMEOUT_CYC);
	wire [7:0] flags_d = {analog2_overflow, analog1_overflow,                      // R13
		time_deviation_over, fd_over,                                          // R14
		ref_lost, mains_absent, time_string_missing,                           // R15
		mains_time_uninit};                                                    // R16

	wire [79:0] prefix_sh = `GDTG_PREFIX >> (8'h48 - {1'b0, pidx_q, 3'h0});
	wire cmd_idle    = (pstate_q == P_IDLE);
	wire cmd_request = rx_take & cmd_idle & ((rx_byte == "T") || (rx_byte == "?"));
	wire cmd_error   = rx_take & cmd_idle & (rx_byte == "E");
	wire corr_ok     = rx_take & (pstate_q == P_LF) & (rx_byte == 8'h0A);

	wire [3:0] int_events;
	assign int_events[`GDTG_INT_SENT]    = tx_last;
	assign int_events[`GDTG_INT_REQUEST] = cmd_request & (mode == `GDTG_MODE_REQUEST);
	assign int_events[`GDTG_INT_CORR]    = corr_ok;
	assign int_events[`GDTG_INT_FLAG]    = ce & |(flags_d & ~flags_q);

	// pulse synchroniser: an edge counts once the second and third stage agree
	always @(posedge sys_clk) begin
		if (rst) begin
			sync1_q     <= 1'b0;
			sync2_q     <= 1'b0;
			sync3_q     <= 1'b0;
			pulse_lvl_q <= 1'b0;
			ref_cnt_q   <= 28'h0000000;
		end else if (ce) begin
			sync1_q <= ref_pulse;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			if (sync2_q == sync3_q)
				pulse_lvl_q <= sync3_q;
			if (sec_edge)
				ref_cnt_q <= 28'h0000000;
			else if (!ref_lost)
				ref_cnt_q <= ref_cnt_q + 28'h0000001;                          // R15
		end
	end

	// ahb-lite slave: zero wait states, read data registered in the address phase
	always @(posedge sys_clk) begin
		if (rst) begin
			wr_pend_q    <= 1'b0;
			wr_addr_q    <= 8'h00;
			hrdata       <= 32'h00000000;
			ctrl_q       <= `GDTG_CTRL_RESET;
			fd_max_q     <= `GDTG_FD_MAX_RESET;
			fd_min_q     <= `GDTG_FD_MIN_RESET;
			int_mask_q   <= 4'h0;
			int_status_q <= 4'h0;
			flags_q      <= 8'h00;
		end else if (ce) begin
			flags_q   <= flags_d;
			wr_pend_q <= ahb_go & hwrite;
			wr_addr_q <= haddr[7:0];
			if (ahb_go && !hwrite) begin
				case (haddr[7:0])
				`GDTG_OFS_CTRL:       hrdata <= {29'h00000000, ctrl_q};
				`GDTG_OFS_FLAGS:      hrdata <= {24'h000000, flags_q};
				`GDTG_OFS_INT_STATUS: hrdata <= {28'h0000000, int_status_q};
				`GDTG_OFS_INT_MASK:   hrdata <= {28'h0000000, int_mask_q};
				`GDTG_OFS_FD_MAX:     hrdata <= {16'h0000, fd_max_q};
				`GDTG_OFS_FD_MIN:     hrdata <= {16'h0000, fd_min_q};
				`GDTG_OFS_CORR:       hrdata <= {11'h000, corr_neg, corr_value};
				default:              hrdata <= 32'h00000000;
				endcase
			end
			if (wr_pend_q) begin
				case (wr_addr_q)
				`GDTG_OFS_CTRL:     ctrl_q     <= hwdata[2:0];
				`GDTG_OFS_INT_MASK: int_mask_q <= hwdata[3:0];
				`GDTG_OFS_FD_MAX:   fd_max_q   <= hwdata[15:0];
				`GDTG_OFS_FD_MIN:   fd_min_q   <= hwdata[15:0];
				default:            ;
				endcase
			end
			// a new event wins over a write-one-to-clear in the same cycle
			if (wr_pend_q && (wr_addr_q == `GDTG_OFS_INT_STATUS))
				int_status_q <= (int_status_q & ~hwdata[3:0]) | int_events;
			else
				int_status_q <= int_status_q | int_events;
		end
	end

	// command parser for requests, error queries and corrections
	always @(posedge sys_clk) begin
		if (rst) begin
			pstate_q   <= P_IDLE;
			pidx_q     <= 4'h0;
			ndig_q     <= 3'h0;
			pneg_q     <= 1'b0;
			pacc_q     <= 20'h00000;
			corr_load  <= 1'b0;
			corr_neg   <= 1'b0;
			corr_value <= 20'h00000;
		end else if (ce) begin
			corr_load <= 1'b0;
			if (rx_take) begin
				case (pstate_q)
				P_IDLE: begin
					if (rx_byte == "F") begin
						pstate_q <= P_PREFIX;
						pidx_q   <= 4'h1;
					end
				end
				P_PREFIX: begin
					if (rx_byte != prefix_sh[7:0]) begin
						pstate_q <= P_IDLE;
					end else if (pidx_q == `GDTG_PREFIX_LEN - 4'h1) begin
						pstate_q <= P_SIGN;
					end else begin
						pidx_q <= pidx_q + 4'h1;
					end
				end
				P_SIGN: begin
					ndig_q <= 3'h0;
					pacc_q <= 20'h00000;
					pneg_q <= (rx_byte == "-");
					if ((rx_byte == "+") || (rx_byte == "-"))
						pstate_q <= P_DIGITS;
					else
						pstate_q <= P_IDLE;
				end
				P_DIGITS: begin
					if (is_digit && (ndig_q != 3'h5)) begin
						pacc_q <= {pacc_q[15:0], rx_byte[3:0]};
						ndig_q <= ndig_q + 3'h1;
					end else if (rx_byte == 8'h0D && ndig_q != 3'h0) begin
						pstate_q <= P_LF;
					end else if (rx_byte != ".") begin
						pstate_q <= P_IDLE;
					end
				end
				P_LF: begin
					pstate_q <= P_IDLE;
					// applied at once, well inside the permitted delay
					if (corr_ok) begin
						corr_load  <= 1'b1;                                     // R9
						corr_neg   <= pneg_q;
						corr_value <= pacc_q;
					end
				end
				default: pstate_q <= P_IDLE;
				endcase
			end
		end
	end

	// scheduling and shift-out of telegrams
	always @(posedge sys_clk) begin
		if (rst) begin
			msg_q       <= 424'h0;
			left_q      <= 6'h00;
			sec_pend_q  <= 1'b0;
			req_pend_q  <= 1'b0;
			err_pend_q  <= 1'b0;
			echo_pend_q <= 1'b0;
		end else if (ce) begin
			if (cmd_request && mode == `GDTG_MODE_REQUEST)
				req_pend_q <= 1'b1;                                             // R7
			if (cmd_error)
				err_pend_q <= 1'b1;                                             // R17
			if (corr_ok)
				echo_pend_q <= 1'b1;                                            // R9
			// the new second is loaded one cycle after its edge so that
			// the time inputs have already rolled over
			if (sec_edge && enabled)
				sec_pend_q <= 1'b1;                                             // R2
			if (tx_fire) begin
				msg_q  <= {msg_q[415:0], 8'h00};
				left_q <= left_q - 6'h01;
			end else if (!tx_busy) begin
				if (echo_pend_q && !corr_ok) begin
					echo_pend_q <= 1'b0;
					msg_q       <= {echo_w, 384'h0};
					left_q      <= `GDTG_LEN_ECHO;
				end else if (err_pend_q && !cmd_error) begin
					err_pend_q <= 1'b0;
					msg_q      <= {err_w, 296'h0};
					left_q     <= `GDTG_LEN_ERROR;
				end else if (sec_pend_q && !sec_edge) begin
					sec_pend_q <= 1'b0;
					case (mode)
					`GDTG_MODE_EXTENDED: begin
						msg_q  <= {ext_w, 88'h0};
						left_q <= `GDTG_LEN_EXTENDED;                           // R1
					end
					`GDTG_MODE_REQUEST: begin
						// a request caught this second waits for the next edge
						if (req_pend_q && !cmd_request) begin
							req_pend_q <= 1'b0;
							msg_q      <= {cmp_w, 152'h0};
							left_q     <= `GDTG_LEN_COMPACT;                    // R6 R7
						end
					end
					`GDTG_MODE_THIRD: begin
						msg_q  <= thd_w;
						left_q <= `GDTG_LEN_THIRD;
					end
					default: ;
					endcase
				end
			end
		end
	end

endmodule

// ==== testbench/gdtg_chk.sv ====
/* Port checker of gdtg_top: transmit handshake and framing, correction
   pulse, receive priority and bus answer. Assumes one clock, sync rst. */
`timescale 1ns/1ps
module gdtg_chk (
	// clock and reset
	input wire        sys_clk,
	input wire        rst,
	// serial streams
	input wire        tx_valid,
	input wire [7:0]  tx_data,
	input wire        tx_ready,
	input wire        rx0_valid,
	input wire [7:0]  rx0_data,
	input wire        rx0_ready,
	input wire        rx1_valid,
	input wire [7:0]  rx1_data,
	input wire        rx1_ready,
	// correction
	input wire        corr_load,
	input wire [19:0] corr_value,
	// bus
	input wire        hsel,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire        hready,
	input wire        hreadyout,
	input wire        hresp,
	input wire [31:0] hrdata
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire rd_w = hsel && htrans[1] && hready && !hwrite;
	wire lf_w = (rx0_valid && rx0_ready && rx0_data == 8'h0A) ||
		(rx1_valid && rx1_ready && rx1_data == 8'h0A);
	sequence cr_sent;
		tx_valid && tx_ready && tx_data == 8'h0D;
	endsequence
	sequence lf_next;
		tx_valid && tx_data == 8'h0A;
	endsequence
	sequence tx_stall;
		tx_valid && !tx_ready;
	endsequence
	a_frame_end_lf: assert property (cr_sent |=> lf_next)
		else $error("carriage return not followed by line feed");
	a_tx_hold: assert property (tx_stall |=> tx_valid && $stable(tx_data))
		else $error("stalled byte changed or dropped");
	a_first_char: assert property ($rose(tx_valid) |->
		tx_data inside {8'h45, 8'h46, 8'h54, [8'h30:8'h39]})
		else $error("message starts with an unexpected character");
	a_corr_cause: assert property (corr_load |-> $past(lf_w))
		else $error("correction load without a line feed before it");
	a_corr_once: assert property (corr_load |=> !corr_load)
		else $error("correction load longer than one cycle");
	a_corr_hold: assert property ($changed(corr_value) |-> corr_load)
		else $error("correction value moved without a load");
	a_rx_priority: assert property (rx0_ready && rx1_ready == !rx0_valid)
		else $error("receive ports not ready as expected");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready and okay");
	a_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_w))
		else $error("read data changed without a read");
	a_reset_quiet: assert property ($past(rst) |-> !tx_valid && !corr_load)
		else $error("outputs active right after reset");
endmodule

// ==== testbench/gdtg_host.sv ====
/* Host at the serial side: takes transmitted bytes into a queue, stalling
   every other cycle when slow, and sends command bytes on either port. */
`timescale 1ns/1ps
module gdtg_host (
	// clock and reset
	input wire        sys_clk,
	input wire        rst,
	// pacing
	input wire        slow,
	// bytes from the device
	input wire        tx_valid,
	input wire [7:0]  tx_data,
	output reg        tx_ready = 1'b0,
	// bytes to the device
	output reg        rx0_valid = 1'b0,
	output reg [7:0]  rx0_data = 8'h00,
	input wire        rx0_ready,
	output reg        rx1_valid = 1'b0,
	output reg [7:0]  rx1_data = 8'hFF,
	input wire        rx1_ready
);
	logic [7:0] got[$];
	always @(posedge sys_clk) begin
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
		tx_ready <= rst ? 1'b0 : (slow ? ~tx_ready : 1'b1);
	end
	// released data lines flip so a stale byte is never mistaken for a new one
	task automatic send(input int p, input string s);
		int n;
		for (int i = 0; i < s.len(); i++) begin
			@(posedge sys_clk);
			if (p == 0) begin
				rx0_valid <= 1'b1;
				rx0_data <= s[i];
			end else begin
				rx1_valid <= 1'b1;
				rx1_data <= s[i];
			end
			n = 0;
			do begin
				@(posedge sys_clk);
				n++;
			end while (!(p == 0 ? rx0_ready : rx1_ready) && n < 50);
			if (n >= 50)
				tb.stop;
			rx0_valid <= 1'b0;
			rx1_valid <= 1'b0;
			rx0_data <= ~rx0_data;
			rx1_data <= ~rx1_data;
		end
	endtask
endmodule

// ==== testbench/tb.sv ====
/* Bench top for gdtg_top: drives the bus, the pulse pin and the measured
   values, checks telegrams through the host model. Assumes 200 MHz. */
`timescale 1ns/1ps
`include "gdtg_regs.vh"
module tb;
	localparam int REF = 4000;
	logic sys_clk = 1'b0, rst = 1'b1, ref_pulse = 1'b0, synced = 1'b1, slow = 1'b0;
	logic tdn = 1'b0, fdn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [7:0] yy = 8'h10, mo = 8'h03, dd = 8'h09, hh = 8'h15, mi = 8'h03, ss = 8'h30;
	logic [7:0] fc = 8'h00;
	logic [3:0] wd = 4'h2;
	logic [11:0] yd = 12'h079, mms = 12'h000;
	logic [19:0] td = 20'h00378, mf = 20'h49984;
	logic [15:0] fd = 16'h0500;
	logic [23:0] mt = 24'h000000;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, d;
	wire rx0_valid, rx0_ready, rx1_valid, rx1_ready, tx_valid, tx_ready;
	wire corr_load, corr_neg, hreadyout, hresp, irq;
	wire [7:0] rx0_data, rx1_data, tx_data;
	wire [19:0] corr_value;
	wire [31:0] hrdata;
	int n_mismatch = 0;
	int compares = 0;
	gdtg_top #(.REF_TIMEOUT_CYC(REF)) u_dut (
		.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .ref_pulse(ref_pulse),
		.ref_year(yy), .ref_month(mo), .ref_day(dd), .ref_wday(wd), .ref_yday(yd),
		.ref_hour(hh), .ref_min(mi), .ref_sec(ss), .synced(synced),
		.time_deviation_neg(tdn), .time_deviation(td), .time_deviation_over(fc[5]),
		.frequency_deviation_neg(fdn), .frequency_deviation(fc[4] ? 16'h0501 : fd),
		.measured_frequency(mf), .mains_derived_time(mt), .mains_derived_ms(mms),
		.analog2_overflow(fc[7]), .analog1_overflow(fc[6]), .mains_absent(fc[2]),
		.time_string_missing(fc[1]), .mains_time_uninit(fc[0]),
		.rx0_valid(rx0_valid), .rx0_data(rx0_data), .rx0_ready(rx0_ready),
		.rx1_valid(rx1_valid), .rx1_data(rx1_data), .rx1_ready(rx1_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.corr_load(corr_load), .corr_neg(corr_neg), .corr_value(corr_value),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .irq(irq));
	gdtg_host u_host (.sys_clk, .rst, .slow, .tx_valid, .tx_data, .tx_ready,
		.rx0_valid, .rx0_data, .rx0_ready, .rx1_valid, .rx1_data, .rx1_ready);
	initial forever #2.5 sys_clk = ~sys_clk;
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task results;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task stop;
		n_mismatch++;
		results;
	endtask
	task rdy;
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (n >= 20)
			stop;
	endtask
	// one single word transfer; read data lands in d
	task bus(input logic w, input logic [31:0] a, input logic [31:0] v);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= v;
		rdy;
		d = hrdata;
	endtask
	task rd(input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk("register", d, e);
	endtask
	task sec;
		ref_pulse <= 1'b1;
		repeat (6) @(posedge sys_clk);
		ref_pulse <= 1'b0;
	endtask
	// waits for a whole line, compares it and its CR LF, then consumes it
	task msg(input string s);
		int n;
		n = 0;
		while (u_host.got.size() < s.len() + 2 && n < 3000) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 3000)
			stop;
		for (int i = 0; i < s.len(); i++)
			chk("tx byte", u_host.got[i], s[i]);
		chk("cr", u_host.got[s.len()], 8'h0D);
		chk("lf", u_host.got[s.len() + 1], 8'h0A);
		repeat (s.len() + 2) void'(u_host.got.pop_front());
	endtask
	initial begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd(`GDTG_OFS_CTRL, `GDTG_CTRL_RESET);
		rd(`GDTG_OFS_FD_MAX, `GDTG_FD_MAX_RESET);
		rd(`GDTG_OFS_FD_MIN, `GDTG_FD_MIN_RESET);
		bus(1'b1, 32'h40, 32'hFFFF);
		rd(32'h40, 32'h0);
		repeat (REF + 60) @(posedge sys_clk);
		rd(`GDTG_OFS_FLAGS, 32'h08);
		for (int i = 0; i < 8; i++) begin
			if (i != 3) begin
				fc <= 8'h01 << i;
				repeat (4) @(posedge sys_clk);
				bus(1'b0, `GDTG_OFS_FLAGS, 32'h0);
				chk("flags", d & 32'hF7, 32'h01 << i);
			end
		end
		fc <= 8'h81;
		slow <= 1'b1;
		sec;
		msg("T:10:03:09:02:15:03:30D:+000.378F:49.984");
		slow <= 1'b0;
		bus(1'b0, `GDTG_OFS_INT_STATUS, 32'h0);
		chk("status", d, 32'h9);
		chk("irq", irq, 1'b0);
		bus(1'b1, `GDTG_OFS_INT_MASK, 32'h1);
		repeat (2) @(posedge sys_clk);
		chk("irq", irq, 1'b1);
		bus(1'b1, `GDTG_OFS_INT_STATUS, 32'h1);
		rd(`GDTG_OFS_INT_STATUS, 32'h8);
		chk("irq", irq, 1'b0);
		for (int p = 0; p < 2; p++) begin
			u_host.send(p, "E");
			msg("ERROR:10000001");
		end
		bus(1'b1, `GDTG_OFS_CTRL, 32'h5);
		hh <= 8'h08;
		mi <= 8'h13;
		ss <= 8'h55;
		td <= 20'h06780;
		fd <= 16'h0012;
		sec;
		repeat (20) @(posedge sys_clk);
		chk("idle", u_host.got.size(), 32'h0);
		for (int k = 0; k < 2; k++) begin
			u_host.send(0, k ? "?" : "T");
			sec;
			msg("079:08:13:55.000 T+06.780F+0.012");
		end
		bus(1'b1, `GDTG_OFS_CTRL, 32'h6);
		yd <= 12'h068;
		hh <= 8'h12;
		mi <= 8'h17;
		td <= 20'h01537;
		tdn <= 1'b1;
		fd <= 16'h0123;
		mf <= 20'h60095;
		mt <= 24'h121753;
		mms <= 12'h463;
		for (int k = 0; k < 2; k++) begin
			synced <= k[0];
			sec;
			if (k)
				msg("068:12:17:55 T-01.537F+0.123SF+60.095ST12:17:53.463");
			else
				msg("068:12:17:55?T-01.537F+0.123SF+60.095ST12:17:53.463");
		end
		bus(1'b1, `GDTG_OFS_CTRL, 32'h0);
		u_host.send(0, "F2X\015\012");
		u_host.send(1, "F27 B3 PS +6.780\015\012");
		msg("F27");
		rd(`GDTG_OFS_CORR, 32'h06780);
		chk("corr", corr_value, 20'h06780);
		u_host.send(1, "F27 B3 PS -1.5\015\012");
		msg("F27");
		rd(`GDTG_OFS_CORR, 32'h00100015);
		bus(1'b0, `GDTG_OFS_INT_STATUS, 32'h0);
		chk("status", d[2], 1'b1);
		repeat (30) @(posedge sys_clk);
		chk("extra", u_host.got.size(), 32'h0);
		results;
	end
endmodule
bind gdtg_top gdtg_chk u_chk (.sys_clk, .rst, .tx_valid, .tx_data, .tx_ready,
	.rx0_valid, .rx0_data, .rx0_ready, .rx1_valid, .rx1_data, .rx1_ready,
	.corr_load, .corr_value, .hsel, .htrans, .hwrite, .hready, .hreadyout,
	.hresp, .hrdata);
